// *** src/rbsm_pkg.sv ***
package rbsm_pkg;

	// Clock and timing
	localparam int  CLK_PERIOD_NS  = 10;
	localparam real TICK_BASE_US   = 25.6;
	// Least time, so round up to whole cycles
	localparam int  TICK_BASE_CYC  = int'($ceil(TICK_BASE_US * 1000.0 / CLK_PERIOD_NS));

	// Geometry
	localparam int  NPAGES         = 32;
	localparam int  PAGE_W         = 5;
	localparam int  DATA_W         = 32;
	localparam int  ADDR_W         = 8;

	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CFG      = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RXMODE   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RXFLAG   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PAGE_SEL = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_PAGE_DAT = 8'h1C;

	// Field positions
	localparam int  CMD_RESET_BIT  = 0;
	localparam int  CMD_WCLR_BIT   = 1;
	localparam int  CFG_TICK_LSB   = 0;
	localparam int  CFG_EXP_LSB    = 4;
	localparam int  ST_REMOTE_RECEIVE_DONE_FLAG_BIT    = 0;
	localparam int  ST_WARN_BIT    = 1;

	// Reset values
	localparam logic        SOFT_RST_RST   = 1'b1;
	localparam logic [1:0]  TICK_SEL_RST   = 2'h0;
	localparam logic [3:0]  PERIOD_EXP_RST = 4'h1;
	localparam logic [31:0] RXMODE_RST     = 32'h0;
	localparam logic [1:0]  MASK_RST       = 2'h0;
	localparam logic [1:0]  STATUS_RST     = 2'h0;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef struct packed {
		logic              valid;
		logic              good;
		logic [PAGE_W-1:0] page;
		logic [DATA_W-1:0] data;
	} rbsm_rx_t;

	typedef struct packed {
		logic [1:0] warn_tick_select;
		logic [3:0] warn_period_exponent;
	} rbsm_cfg_t;

endpackage

// *** src/rbsm_page_mem.sv ***
`timescale 1ns/100ps
module rbsm_page_mem import rbsm_pkg::*; #(
	parameter int DEPTH = NPAGES,
	parameter int WIDTH = DATA_W
) (
	input  wire logic                     mclk,
	input  wire logic                     clk_en,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data_ff
);

	logic [WIDTH-1:0] mem [DEPTH];

	generate
		if (DEPTH < 2) begin : g_chk
			$error("rbsm_page_mem: DEPTH must be at least 2");
		end
	endgenerate

	// No reset on the array: contents are undefined until a page is written
	always_ff @(posedge mclk) begin
		if (clk_en) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data_ff <= mem[rd_addr];
		end
	end

endmodule

// *** src/rbsm_top.sv ***
// Behaviour
// R01 - Mode bit one selects remote-buffer monitoring
// R02 - Remote reception completion sets receive-done flag
// R03 - AND flags each period; all set clears them
// R04 - AND zero at period end sets warning
// R05 - Warning stays until clear command
// R06 - Clear command clears only the warning
// R07 - Monitoring starts when software reset releases
// R08 - Host programs settings under software reset
// R09 - Host masks warning, clears, then unmasks
// R10 - Period is tick times two to N
// R11 - Tick select doubles resolution per code
// R12 - Newest packet overwrites its source page
// R13 - Page flag means packet arrived this period; the code keeps flags through a period that ends with a page unheard
// R14 - Count ticks to two to N, restart
`timescale 1ns/100ps
module rbsm_top import rbsm_pkg::*; #(
	parameter int TICK_CYC = TICK_BASE_CYC,
	parameter int PAGES    = NPAGES
) (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	input  wire rbsm_rx_t          rx_evt,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   irq
);

	localparam int PW = $clog2(PAGES);

	generate
		if (PAGES < 2 || PAGES > 32 || PW > PAGE_W) begin : g_chk_pages
			$error("rbsm_top: PAGES must lie in 2..32");
		end
		if (TICK_CYC < 1 || TICK_CYC > 8191) begin : g_chk_tick
			$error("rbsm_top: TICK_CYC must lie in 1..8191");
		end
	endgenerate

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == OFF_CMD) || (a == OFF_CFG) || (a == OFF_RXMODE) ||
			(a == OFF_STATUS) || (a == OFF_MASK) || (a == OFF_RXFLAG) ||
			(a == OFF_PAGE_SEL) || (a == OFF_PAGE_DAT);
	endfunction

	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		merge = r;
	endfunction

	// Register file state
	logic             soft_rst_ff,  nxt_soft_rst;
	rbsm_cfg_t        cfg_ff,       nxt_cfg;
	logic [PAGES-1:0] mode_ff,      nxt_mode;
	logic [1:0]       mask_ff,      nxt_mask;
	logic [1:0]       status_ff,    nxt_status;
	logic [PW-1:0]    page_sel_ff,  nxt_page_sel;

	// Monitor state
	logic [PAGES-1:0] rxf_ff,       nxt_rxf;
	logic [15:0]      pre_cnt_ff,   nxt_pre_cnt;
	logic [15:0]      per_cnt_ff,   nxt_per_cnt;

	// Bus state
	logic              aw_got_ff,   nxt_aw_got;
	logic [ADDR_W-1:0] awaddr_ff,   nxt_awaddr;
	logic              w_got_ff,    nxt_w_got;
	logic [31:0]       wdata_ff,    nxt_wdata;
	logic [3:0]        wstrb_ff,    nxt_wstrb;
	logic              bvalid_ff,   nxt_bvalid;
	logic [1:0]        bresp_ff,    nxt_bresp;
	logic              rvalid_ff,   nxt_rvalid;
	logic [31:0]       rdata_ff,    nxt_rdata;
	logic [1:0]        rresp_ff,    nxt_rresp;

	logic [DATA_W-1:0] mem_rd_data;

	// Datapath helpers
	logic              aw_fire, w_fire, ar_fire, do_write;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              rx_store;
	logic [PAGES-1:0]  rx_set;
	logic [15:0]       tick_cyc;
	logic [15:0]       period_ticks;
	logic              tick, period_end, all_heard, wclr_cmd;
	logic [31:0]       cmd_word, cfg_word, mode_word;

	assign s_axi_awready = clk_en && !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = clk_en && !w_got_ff && !bvalid_ff;
	assign s_axi_arready = clk_en && !rvalid_ff;
	assign aw_fire  = s_axi_awvalid && s_axi_awready;
	assign w_fire   = s_axi_wvalid && s_axi_wready;
	assign ar_fire  = s_axi_arvalid && s_axi_arready;
	assign wr_addr  = aw_got_ff ? awaddr_ff : s_axi_awaddr;
	assign wr_data  = w_got_ff ? wdata_ff : s_axi_wdata;
	assign wr_strb  = w_got_ff ? wstrb_ff : s_axi_wstrb;
	assign do_write = (aw_got_ff || aw_fire) && (w_got_ff || w_fire) && !bvalid_ff;

	assign cmd_word  = {30'h0, 1'b0, soft_rst_ff};
	assign cfg_word  = {24'h0, cfg_ff.warn_period_exponent, 2'h0, cfg_ff.warn_tick_select};
	assign mode_word = 32'(mode_ff);

	// Only remote-buffer pages are captured here; free-format pages belong elsewhere
	assign rx_store = rx_evt.valid && rx_evt.good &&
		(int'(rx_evt.page) < PAGES) && mode_ff[rx_evt.page[PW-1:0]]; // see R01
	assign rx_set   = rx_store ? (PAGES'(1) << rx_evt.page[PW-1:0]) : '0; // see R13

	// Tick length doubles per select code
	assign tick_cyc     = 16'(TICK_CYC) << cfg_ff.warn_tick_select; // see R11
	assign period_ticks = 16'h1 << cfg_ff.warn_period_exponent; // see R10
	assign tick         = !soft_rst_ff && (pre_cnt_ff == tick_cyc - 16'h1);
	// Exponent zero is illegal: the period never ends rather than running at one tick
	assign period_end   = tick && (cfg_ff.warn_period_exponent != 4'h0) &&
		(per_cnt_ff == period_ticks - 16'h1); // see R14
	assign all_heard    = &(rxf_ff | ~mode_ff); // see R03

	assign wclr_cmd = do_write && (wr_addr == OFF_CMD) && wr_strb[0] &&
		wr_data[CMD_WCLR_BIT];

	always_comb begin
		nxt_soft_rst = soft_rst_ff;
		nxt_cfg      = cfg_ff;
		nxt_mode     = mode_ff;
		nxt_mask     = mask_ff;
		nxt_page_sel = page_sel_ff;
		nxt_status   = status_ff;
		if (do_write) begin
			unique case (wr_addr)
				OFF_CMD: begin
					if (wr_strb[0]) begin
						nxt_soft_rst = wr_data[CMD_RESET_BIT]; // see R08
					end
				end
				OFF_CFG: begin
					if (wr_strb[0]) begin
						nxt_cfg.warn_tick_select     = wr_data[CFG_TICK_LSB +: 2];
						nxt_cfg.warn_period_exponent = wr_data[CFG_EXP_LSB +: 4];
					end
				end
				OFF_RXMODE:   nxt_mode = PAGES'(merge(mode_word, wr_data, wr_strb));
				OFF_MASK: begin
					if (wr_strb[0]) begin
						nxt_mask = wr_data[1:0];
					end
				end
				OFF_PAGE_SEL: begin
					if (wr_strb[0]) begin
						nxt_page_sel = wr_data[PW-1:0];
					end
				end
				OFF_STATUS: begin
					// Write one clears the receive-done flag; the warning ignores it
					if (wr_strb[0] && wr_data[ST_REMOTE_RECEIVE_DONE_FLAG_BIT]) begin
						nxt_status[ST_REMOTE_RECEIVE_DONE_FLAG_BIT] = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (wclr_cmd) begin
			nxt_status[ST_WARN_BIT] = 1'b0; // see R06
		end
		// Setting after clearing: an event in the clear cycle is kept
		if (rx_store) begin
			nxt_status[ST_REMOTE_RECEIVE_DONE_FLAG_BIT] = 1'b1; // see R02
		end
		if (period_end && !all_heard) begin
			nxt_status[ST_WARN_BIT] = 1'b1; // see R04
		end
	end

	// Monitor: runs as soon as software reset is low, no start command
	always_comb begin
		nxt_pre_cnt = pre_cnt_ff;
		nxt_per_cnt = per_cnt_ff;
		nxt_rxf     = rxf_ff;
		if (soft_rst_ff) begin
			nxt_pre_cnt = '0;
			nxt_per_cnt = '0;
			nxt_rxf     = '0;
		end else begin
			nxt_pre_cnt = tick ? 16'h0 : pre_cnt_ff + 16'h1; // see R07
			if (period_end) begin
				nxt_per_cnt = '0; // see R14
			end else if (tick) begin
				nxt_per_cnt = per_cnt_ff + 16'h1;
			end
			// Flags of a failed period are kept, so the silent page stays visible
			if (period_end && all_heard) begin
				nxt_rxf = rxf_ff & ~mode_ff; // see R03
			end
			nxt_rxf = nxt_rxf | rx_set; // see R13
		end
	end

	// Bus channels
	always_comb begin
		nxt_aw_got = aw_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_w_got  = w_got_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (aw_fire) begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (w_fire) begin
			nxt_w_got = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_aw_got = 1'b0;
			nxt_w_got  = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (ar_fire) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				OFF_CMD:      nxt_rdata = cmd_word;
				OFF_CFG:      nxt_rdata = cfg_word;
				OFF_RXMODE:   nxt_rdata = mode_word;
				OFF_STATUS:   nxt_rdata = {30'h0, status_ff};
				OFF_MASK:     nxt_rdata = {30'h0, mask_ff};
				OFF_RXFLAG:   nxt_rdata = 32'(rxf_ff);
				OFF_PAGE_SEL: nxt_rdata = 32'(page_sel_ff);
				// Memory output lags the select by one cycle; a read right after
				// a select write returns the previous page
				OFF_PAGE_DAT: nxt_rdata = 32'(mem_rd_data);
				default:      nxt_rdata = 32'h0;
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			soft_rst_ff <= SOFT_RST_RST;
			cfg_ff      <= '{warn_tick_select: TICK_SEL_RST,
				warn_period_exponent: PERIOD_EXP_RST};
			mode_ff     <= PAGES'(RXMODE_RST);
			mask_ff     <= MASK_RST;
			status_ff   <= STATUS_RST;
			page_sel_ff <= '0;
			rxf_ff      <= '0;
			pre_cnt_ff  <= '0;
			per_cnt_ff  <= '0;
			aw_got_ff   <= 1'b0;
			awaddr_ff   <= '0;
			w_got_ff    <= 1'b0;
			wdata_ff    <= '0;
			wstrb_ff    <= '0;
			bvalid_ff   <= 1'b0;
			bresp_ff    <= RESP_OKAY;
			rvalid_ff   <= 1'b0;
			rdata_ff    <= '0;
			rresp_ff    <= RESP_OKAY;
		end else if (clk_en) begin
			soft_rst_ff <= nxt_soft_rst;
			cfg_ff      <= nxt_cfg;
			mode_ff     <= nxt_mode;
			mask_ff     <= nxt_mask;
			status_ff   <= nxt_status; // see R05
			page_sel_ff <= nxt_page_sel;
			rxf_ff      <= nxt_rxf;
			pre_cnt_ff  <= nxt_pre_cnt;
			per_cnt_ff  <= nxt_per_cnt;
			aw_got_ff   <= nxt_aw_got;
			awaddr_ff   <= nxt_awaddr;
			w_got_ff    <= nxt_w_got;
			wdata_ff    <= nxt_wdata;
			wstrb_ff    <= nxt_wstrb;
			bvalid_ff   <= nxt_bvalid;
			bresp_ff    <= nxt_bresp;
			rvalid_ff   <= nxt_rvalid;
			rdata_ff    <= nxt_rdata;
			rresp_ff    <= nxt_rresp;
		end
	end

	rbsm_page_mem #(
		.DEPTH (PAGES),
		.WIDTH (DATA_W)
	) u_page_mem (
		.mclk       (mclk),
		.clk_en     (clk_en),
		.wr_en      (rx_store), // see R12
		.wr_addr    (rx_evt.page[PW-1:0]),
		.wr_data    (rx_evt.data),
		.rd_addr    (page_sel_ff),
		.rd_data_ff (mem_rd_data)
	);

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;
	assign irq          = |(status_ff & mask_ff); // see R02 R04

endmodule

// *** test/rbsm_top_sva.sv ***
`timescale 1ns/100ps
module rbsm_top_sva (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("write answer late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_b_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_b_drop: assert property (clk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_en_freeze: assert property (!clk_en |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while disabled");
	a_irq_freeze: assert property (!clk_en |=> $stable(irq))
		else $error("irq moved while disabled");
	// Status and mask only drop through a bus write, so a fall follows one
	a_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid)
		else $error("irq fell without a write");
endmodule
bind rbsm_top rbsm_top_sva chk_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .irq(irq));

// *** test/rbsm_rx_src.sv ***
`timescale 1ns/100ps
module rbsm_rx_src import rbsm_pkg::*; (
	input  wire logic              mclk,
	input  wire logic              send,
	input  wire logic              good,
	input  wire logic [PAGE_W-1:0] page,
	input  wire logic [DATA_W-1:0] data,
	output rbsm_rx_t               rx
);
	// Idle payload is inverted so nothing can lean on a stale packet
	always @(posedge mclk) begin
		rx.valid <= send;
		rx.good  <= send ? good : ~good;
		rx.page  <= send ? page : ~page;
		rx.data  <= send ? data : ~data;
	end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	import rbsm_pkg::*;
	localparam int TK = 4;
	localparam logic [31:0] RST_V [6] = '{32'h1, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0};
	logic              mclk, reset_n, clk_en, send, good, irq;
	logic [PAGE_W-1:0] page;
	logic [31:0]       data, wdata, rdata, rd, m_mode;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [3:0]        wstrb;
	logic [2:0]        prot;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [1:0]        bresp, rresp, m_st, m_mask;
	logic [31:0]       m_mem [8];
	rbsm_rx_t          rx;
	int                error_cnt = 0, num_checks = 0, cyc = 0, seed, e, t0, tp;

	rbsm_rx_src src (.mclk(mclk), .send(send), .good(good), .page(page), .data(data), .rx(rx));
	rbsm_top #(.TICK_CYC(TK)) uut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
		.rx_evt(rx), .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
			input logic [1:0] er);
		int n;
		n = 0;
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		do begin
			@(posedge mclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (arready)
				arvalid <= 1'b0;
		end while (!(w ? bvalid : rvalid));
		rd = rdata;
		// Answer stands one cycle after the request is taken
		chk(32'(n), 32'h2);
		chk(32'(w ? bresp : rresp), 32'(er));
		bready <= 1'b0;
		rready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic st_chk;
		xfer(1'b0, OFF_STATUS, 32'h0, RESP_OKAY);
		chk(rd, 32'(m_st));
		chk(32'(irq), 32'(|(m_st & m_mask)));
	endtask

	task automatic pkt(input logic [4:0] p, input logic g, input logic [31:0] d);
		send <= 1'b1;
		good <= g;
		page <= p;
		data <= d;
		@(posedge mclk);
		send <= 1'b0;
		@(posedge mclk);
		if (g && m_mode[p]) begin
			m_st[0] = 1'b1;
			m_mem[p[2:0]] = d;
		end
	endtask

	task automatic pkts;
		for (int p = 0; p < 8; p++)
			pkt(5'(p), 1'b1, $random(seed));
	endtask

	task automatic wait_to(input int t);
		while (cyc < t)
			@(posedge mclk);
	endtask

	initial begin
		// Four passes of four periods, the longest period 2048 cycles
		repeat (40000) @(posedge mclk);
		error_cnt++;
		wrap_up();
	end

	initial begin
		seed = 32'h2FAC815A;
		{reset_n, send, good, page, data} <= '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, prot} <= '0;
		clk_en <= 1'b1;
		wstrb <= 4'hF;
		m_st = 2'h0;
		m_mask = 2'h0;
		m_mode = 32'h0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		clk_en <= 1'b0;
		repeat (3) @(posedge mclk);
		clk_en <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 6; i++) begin
			xfer(1'b0, ADDR_W'(4 * i), 32'h0, RESP_OKAY);
			chk(rd, RST_V[i]);
		end
		xfer(1'b0, 8'h40, 32'h0, RESP_SLVERR);
		chk(rd, 32'h0);
		xfer(1'b1, 8'h44, 32'hFFFFFFFF, RESP_SLVERR);
		for (int s = 0; s < 4; s++) begin
			e = 5 + ($unsigned($random(seed)) % 2);
			tp = (TK << s) << e;
			// Pages 1 and 2 always watched, page 3 left free-format
			m_mode = ($random(seed) & 32'hF7) | 32'h6;
			m_mask = 2'h0;
			xfer(1'b1, OFF_CMD, 32'h1, RESP_OKAY);
			xfer(1'b1, OFF_MASK, 32'h0, RESP_OKAY);
			xfer(1'b1, OFF_RXMODE, m_mode, RESP_OKAY);
			xfer(1'b1, OFF_CFG, 32'((e << 4) | s), RESP_OKAY);
			xfer(1'b1, OFF_CMD, 32'h0, RESP_OKAY);
			t0 = cyc - 1;
			xfer(1'b1, OFF_CMD, 32'h2, RESP_OKAY);
			m_st[1] = 1'b0;
			m_mask = 2'h3;
			xfer(1'b1, OFF_MASK, 32'h3, RESP_OKAY);
			pkts();
			pkt(5'h1, 1'b0, $random(seed));
			xfer(1'b0, OFF_RXFLAG, 32'h0, RESP_OKAY);
			chk(rd, m_mode);
			st_chk();
			xfer(1'b1, OFF_PAGE_SEL, 32'h1, RESP_OKAY);
			xfer(1'b0, OFF_PAGE_DAT, 32'h0, RESP_OKAY);
			chk(rd, m_mem[1]);
			xfer(1'b1, OFF_STATUS, 32'h1, RESP_OKAY);
			m_st[0] = 1'b0;
			wait_to(t0 + tp + 6);
			xfer(1'b0, OFF_RXFLAG, 32'h0, RESP_OKAY);
			chk(rd, 32'h0);
			st_chk();
			wait_to(t0 + 2 * tp - 8);
			st_chk();
			wait_to(t0 + 2 * tp + 6);
			m_st[1] = 1'b1;
			st_chk();
			pkts();
			wait_to(t0 + 3 * tp + 6);
			st_chk();
			// Warning bit must ignore a write-one-to-clear attempt
			xfer(1'b1, OFF_STATUS, 32'h2, RESP_OKAY);
			st_chk();
			xfer(1'b1, OFF_CMD, 32'h2, RESP_OKAY);
			m_st[1] = 1'b0;
			st_chk();
			wait_to(t0 + 4 * tp - 8);
			st_chk();
			wait_to(t0 + 4 * tp + 6);
			m_st[1] = 1'b1;
			st_chk();
		end
		wrap_up();
	end
endmodule
